// ==== include/pdb_defines.svh ====
// Timing and layout constants for the parallel display bus block
`ifndef PDB_DEFINES_SVH
`define PDB_DEFINES_SVH

// ****************************************************************
// Clock and strobe timing
// ****************************************************************
`define PDB_CLK_PERIOD_NS 5
`define PDB_WR_LOW_NS 50
`define PDB_WR_HIGH_NS 50
`define PDB_RD_LOW_NS 150
`define PDB_RD_HIGH_NS 150
// Least times round up to whole cycles
`define PDB_CYC(ns) (((ns) + `PDB_CLK_PERIOD_NS - 1) / `PDB_CLK_PERIOD_NS)
`define PDB_WR_LOW_CYC `PDB_CYC(`PDB_WR_LOW_NS)
`define PDB_WR_HIGH_CYC `PDB_CYC(`PDB_WR_HIGH_NS)
`define PDB_RD_LOW_CYC `PDB_CYC(`PDB_RD_LOW_NS)
`define PDB_RD_HIGH_CYC `PDB_CYC(`PDB_RD_HIGH_NS)

// ****************************************************************
// Widths, depths and reset values
// ****************************************************************
`define PDB_DATA_W 16
`define PDB_CNT_W 8
`define PDB_FIFO_DEPTH 16
`define PDB_DATA_RST 16'h0000
`define PDB_CNT_RST 8'h00

`endif

// ==== include/pdb_pkg.sv ====
// Types shared by the parallel display bus block
`include "pdb_defines.svh"

package pdb_pkg;

    // One queued bus transfer
    typedef struct packed {
        logic is_read;                      // Read strobe cycle, else write
        logic register_select;              // Low: index, high: data
        logic [`PDB_DATA_W-1:0] data;       // Write word, unused on reads
    } pdb_cmd_type;

    // Pins of the display side
    typedef struct packed {
        logic [`PDB_DATA_W-1:0] data_out;   // Word driven on the bus
        logic data_oe;                      // High while we drive the bus
        logic write_strobe_n;               // Write strobe, active low
        logic read_strobe_n;                // Read strobe, active low
        logic register_select;              // Index or data select
        logic display_select_n;             // Chip select, active low
        logic display_reset_n;              // Display reset, active low
    } pdb_pins_type;

endpackage : pdb_pkg

// ==== rtl/pdb_display_bus.sv ====
// Command FIFO and 16-bit parallel display bus master
`timescale 1ns/1ps
`include "pdb_defines.svh"

// ****************************************************************
// Command FIFO
// ****************************************************************
module pdb_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,              // System clock
    input wire logic rst,                   // Sync reset, active high
    input wire logic ce,                    // Clock enable
    input wire logic in_valid,              // Source has a word
    output logic in_ready,                  // Room for a word
    input wire logic [WIDTH-1:0] in_data,   // Word in
    output logic out_valid,                 // Word available
    input wire logic out_ready,             // Sink takes a word
    output logic [WIDTH-1:0] out_data       // Word out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic [AW:0] count_d;
    logic in_ready_q;
    logic push;
    logic pop;

    // Handshakes; ready is a flop so it never loops back combinationally
    assign push = ce && in_valid && in_ready_q;
    assign pop = ce && out_ready && (count_q != '0);
    assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
    assign in_ready = in_ready_q;
    assign out_valid = (count_q != '0);
    assign out_data = mem[rd_ptr_q];

    // Storage, no reset needed
    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    // Pointers and fill level; depth must be a power of two
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            in_ready_q <= 1'b0;
        end
        else if (ce)
        begin
            if (push)
            begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            count_q <= count_d;
            in_ready_q <= (count_d != (AW+1)'(DEPTH));
        end
    end
endmodule : pdb_fifo

// ****************************************************************
// Display bus master
// ****************************************************************
module pdb_display_bus (
    input wire logic core_clk,                      // System clock, 200 MHz
    input wire logic rst,                           // Sync reset, active high
    input wire logic ce,                            // Clock enable, freezes all
    input wire logic release_display,               // High lets display run
    input wire logic cmd_valid,                     // Command offered
    output logic cmd_ready,                         // Command queue has room
    input wire pdb_pkg::pdb_cmd_type cmd,           // Queued command
    output logic rd_valid,                          // One-cycle read result
    output logic [`PDB_DATA_W-1:0] rd_data,         // Word read back
    output logic rd_refused,                        // Read dropped, no address
    output logic addr_selected,                     // An index write is in place
    output logic busy,                              // Transfer in progress
    input wire logic [`PDB_DATA_W-1:0] display_data_in, // Bus level in
    output pdb_pkg::pdb_pins_type pins              // Display side pins
);
    import pdb_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH} pdb_state_type;

    pdb_state_type state_q;
    pdb_cmd_type cur_q;
    pdb_cmd_type head;
    pdb_pins_type pins_q;
    logic head_valid;
    logic head_take;
    logic [`PDB_CNT_W-1:0] cnt_q;
    logic last_low;
    logic last_high;
    logic addr_sel_q;
    logic rd_valid_q;
    logic rd_refused_q;
    logic busy_q;
    logic [`PDB_DATA_W-1:0] rd_data_q;

    // Sixteen-deep queue decouples the user from slow strobe timing
    pdb_fifo #(
        .WIDTH($bits(pdb_cmd_type)),
        .DEPTH(`PDB_FIFO_DEPTH)
    ) u_cmd_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data(cmd),
        .out_valid(head_valid),
        .out_ready(head_take),
        .out_data(head)
    );

    // Take one command per idle slot
    assign head_take = ce && (state_q == ST_IDLE);
    assign last_low = (state_q == ST_LOW) && (cnt_q == `PDB_CNT_RST);
    assign last_high = (state_q == ST_HIGH) && (cnt_q == `PDB_CNT_RST);

    // Sequencer: setup, strobe low, strobe high (hold), then idle
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            cnt_q <= `PDB_CNT_RST;
            cur_q <= '0;
        end
        else if (ce)
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    // A read with no address in place is dropped
                    if (head_valid && (!head.is_read || addr_sel_q))
                    begin
                        cur_q <= head;
                        state_q <= ST_SETUP;
                    end
                end
                ST_SETUP:
                begin
                    state_q <= ST_LOW;
                    cnt_q <= cur_q.is_read ? `PDB_CNT_W'(`PDB_RD_LOW_CYC - 1)
                                           : `PDB_CNT_W'(`PDB_WR_LOW_CYC - 1);
                end
                ST_LOW:
                begin
                    if (last_low)
                    begin
                        state_q <= ST_HIGH;
                        cnt_q <= cur_q.is_read ? `PDB_CNT_W'(`PDB_RD_HIGH_CYC - 1)
                                               : `PDB_CNT_W'(`PDB_WR_HIGH_CYC - 1);
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                ST_HIGH:
                begin
                    // High phase also holds data and select past the edge
                    if (last_high)
                    begin
                        state_q <= ST_IDLE;
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
            endcase
        end
    end

    // Bus, select and strobe pins follow the sequencer state
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pins_q.data_out <= `PDB_DATA_RST;
            pins_q.data_oe <= 1'b0;
            pins_q.write_strobe_n <= 1'b1;
            pins_q.read_strobe_n <= 1'b1;
            pins_q.register_select <= 1'b0;
            pins_q.display_select_n <= 1'b1;
        end
        else if (ce)
        begin
            if (state_q == ST_IDLE && head_valid && (!head.is_read || addr_sel_q))
            begin
                pins_q.display_select_n <= 1'b0;
                pins_q.register_select <= head.register_select;
                pins_q.data_out <= head.data;
                pins_q.data_oe <= !head.is_read;
            end
            else if (state_q == ST_SETUP)
            begin
                pins_q.write_strobe_n <= cur_q.is_read;
                pins_q.read_strobe_n <= !cur_q.is_read;
            end
            else if (last_low)
            begin
                // Rising edge: display latches writes, read data captured on this same edge
                pins_q.write_strobe_n <= 1'b1;
                pins_q.read_strobe_n <= 1'b1;
            end
            else if (last_high)
            begin
                pins_q.display_select_n <= 1'b1;
                pins_q.data_oe <= 1'b0;
            end
        end
    end

    // Display reset follows the release request
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pins_q.display_reset_n <= 1'b0;
        end
        else if (ce)
        begin
            pins_q.display_reset_n <= release_display;
        end
    end

    // Address tracking; a completing index write wins over a display reset
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            addr_sel_q <= 1'b0;
        end
        else if (ce)
        begin
            if (last_high && !cur_q.is_read && !cur_q.register_select)
            begin
                addr_sel_q <= 1'b1;
            end
            else if (!pins_q.display_reset_n)
            begin
                addr_sel_q <= 1'b0;
            end
        end
    end

    // Read capture in the last low cycle, on the same edge that raises the strobe
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rd_valid_q <= 1'b0;
            rd_data_q <= `PDB_DATA_RST;
            rd_refused_q <= 1'b0;
            busy_q <= 1'b0;
        end
        else if (ce)
        begin
            rd_valid_q <= last_low && cur_q.is_read;
            if (last_low && cur_q.is_read)
            begin
                rd_data_q <= display_data_in;
            end
            rd_refused_q <= (state_q == ST_IDLE) && head_valid && head.is_read
                            && !addr_sel_q;
            busy_q <= (state_q != ST_IDLE) ? !last_high
                      : (head_valid && (!head.is_read || addr_sel_q));
        end
    end

    assign pins = pins_q;
    assign rd_valid = rd_valid_q;
    assign rd_data = rd_data_q;
    assign rd_refused = rd_refused_q;
    assign addr_selected = addr_sel_q;
    assign busy = busy_q;
endmodule : pdb_display_bus

// ==== sim/pdb_display_bus_asserts.sv ====
// Strobe timing and bus ownership checker for the display bus master
`timescale 1ns/1ps
module pdb_display_bus_asserts (
    input wire logic core_clk, // Clock
    input wire logic rst, // Sync reset
    input wire logic ce, // Enable
    input wire logic release_display, // Run request
    input wire logic rd_valid, // Read done
    input wire logic rd_refused, // Read dropped
    input wire logic addr_selected, // Index set
    input wire pdb_pkg::pdb_pins_type pins // Pins
);
    import pdb_pkg::*;
    logic [7:0] wr_run_q;
    logic [7:0] rd_run_q;
    logic [1:0] prev_q;
    logic rd_prev_q;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ****
    // Strobe run lengths
    // ****
    // Cycles spent at the old level; saturates so long idles never wrap
    always_ff @(posedge core_clk)
    begin
        prev_q <= {pins.write_strobe_n, pins.read_strobe_n};
        if (rst || pins.write_strobe_n != prev_q[1])
            wr_run_q <= rst ? 8'hff : 8'h01;
        else if (wr_run_q != 8'hff)
            wr_run_q <= wr_run_q + 8'h01;
        if (rst || pins.read_strobe_n != prev_q[0])
            rd_run_q <= rst ? 8'hff : 8'h01;
        else if (rd_run_q != 8'hff)
            rd_run_q <= rd_run_q + 8'h01;
    end
    // Read strobe level at the last enabled edge; a frozen pulse stands longer
    always_ff @(posedge core_clk)
    begin
        if (rst)
            rd_prev_q <= 1'b1;
        else if (ce)
            rd_prev_q <= pins.read_strobe_n;
    end
    property p_wr_low;
        $rose(pins.write_strobe_n) |-> wr_run_q >= 8'h0a;
    endproperty
    a_wr_low: assert property (p_wr_low) else $error("write low short");
    property p_wr_high;
        $fell(pins.write_strobe_n) |-> wr_run_q >= 8'h0a;
    endproperty
    a_wr_high: assert property (p_wr_high) else $error("write high short");
    property p_rd_low;
        $rose(pins.read_strobe_n) |-> rd_run_q >= 8'h1e;
    endproperty
    a_rd_low: assert property (p_rd_low) else $error("read low short");
    property p_rd_high;
        $fell(pins.read_strobe_n) |-> rd_run_q >= 8'h1e;
    endproperty
    a_rd_high: assert property (p_rd_high) else $error("read high short");
    // Word and select must not move under a low write strobe
    property p_wr_hold;
        !pins.write_strobe_n |=> !pins.display_select_n && pins.data_oe
            && $stable(pins.data_out) && $stable(pins.register_select);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write word moved");
    property p_rd_bus;
        !pins.read_strobe_n |-> !pins.data_oe && !pins.display_select_n;
    endproperty
    a_rd_bus: assert property (p_rd_bus) else $error("bus driven in read");
    // Judged on enabled edges only, since a freeze holds the result pulse
    property p_rd_done;
        ce |-> rd_valid == (pins.read_strobe_n && !rd_prev_q);
    endproperty
    a_rd_done: assert property (p_rd_done) else $error("read result misplaced");
    property p_rd_addr;
        $fell(pins.read_strobe_n) |-> addr_selected && !rd_refused;
    endproperty
    a_rd_addr: assert property (p_rd_addr) else $error("read without index");
    property p_reset;
        ce && !rst |=> pins.display_reset_n == $past(release_display);
    endproperty
    a_reset: assert property (p_reset) else $error("display reset wrong");
    c_write: cover property ($rose(pins.write_strobe_n));
    c_read: cover property (rd_valid);
    c_refuse: cover property (rd_refused);
endmodule : pdb_display_bus_asserts

bind pdb_display_bus pdb_display_bus_asserts pdb_display_bus_asserts_i (.core_clk, .rst,
    .ce, .release_display, .rd_valid, .rd_refused, .addr_selected, .pins);

// ==== sim/pdb_display_model.sv ====
// Behavioural display module on the far side of the bus
`timescale 1ns/1ps
module pdb_display_model (
    input wire logic core_clk, // Bench clock
    input wire pdb_pkg::pdb_pins_type pins, // Master pins
    input wire logic slow, // Late read data
    output logic [15:0] bus_level // Resolved wire
);
    import pdb_pkg::*;
    logic [15:0] mem_q [16];
    logic [15:0] last_q;
    logic [3:0] idx_q;
    logic [7:0] rd_cnt_q;
    logic wr_q;
    // Latch on the strobe's rising edge; ignored while held in reset
    always_ff @(posedge core_clk)
    begin
        wr_q <= pins.write_strobe_n;
        if (pins.display_reset_n && !pins.display_select_n
            && pins.write_strobe_n && !wr_q)
        begin
            if (!pins.register_select)
                idx_q <= bus_level[3:0];
            else
                mem_q[idx_q] <= bus_level;
        end
    end
    // Read strobe low time, for slow access
    always_ff @(posedge core_clk)
    begin
        last_q <= bus_level;
        rd_cnt_q <= pins.read_strobe_n ? 8'h00 : rd_cnt_q + 8'h01;
    end
    // Undriven wire toggles, so a stale word can never pass as read data
    always_comb
    begin
        bus_level = ~last_q;
        if (pins.data_oe)
            bus_level = pins.data_out;
        else if (!pins.read_strobe_n && !pins.display_select_n
            && rd_cnt_q >= (slow ? 8'h18 : 8'h01))
            bus_level = mem_q[idx_q];
    end
endmodule : pdb_display_model

// ==== sim/pdb_display_bus_bench.sv ====
// Self-checking bench for the display bus master
`timescale 1ns/1ps
module pdb_display_bus_bench;
    import pdb_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic release_display = 1'b0;
    logic cmd_valid = 1'b0;
    pdb_cmd_type cmd = '0;
    logic slow = 1'b0;
    logic cmd_ready, rd_valid, rd_refused, addr_selected, busy;
    logic [15:0] rd_data;
    logic [15:0] bus_level;
    pdb_pins_type pins;
    logic full_seen = 1'b0;
    logic idx_ok = 1'b0;
    logic [3:0] idx = 4'h0;
    logic [15:0] mem [16];
    logic [16:0] exp_q [$];
    logic [16:0] e;
    int failures = 0;
    int checks_done = 0;

    pdb_display_bus pdb_display_bus_i (.core_clk, .rst, .ce, .release_display, .cmd_valid,
        .cmd_ready, .cmd, .rd_valid, .rd_data, .rd_refused, .addr_selected, .busy,
        .display_data_in(bus_level), .pins);
    pdb_display_model pdb_display_model_i (.core_clk, .pins, .slow, .bus_level);

    // Clock
    initial forever #2.5 core_clk = ~core_clk;

    task chk1(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask : chk1

    task chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask : chk16

    // Offer one command, hold it until taken, then note what it should do
    task send(input logic r, input logic rs, input logic [15:0] d);
        logic ok;
        cmd = {r, rs, d};
        cmd_valid = 1'b1;
        do
        begin
            ok = cmd_ready && ce;
            full_seen = full_seen | !cmd_ready;
            @(posedge core_clk);
            #1;
        end
        while (!ok);
        if (r)
            exp_q.push_back(idx_ok ? {1'b0, mem[idx]} : 17'h10000);
        if (!r && !rs)
            idx = d[3:0];
        idx_ok = idx_ok | (!r && !rs);
        if (!r && rs)
            mem[idx] = d;
    endtask : send

    // Idle until the bus has been quiet for eight cycles
    task drain;
        int q;
        cmd_valid = 1'b0;
        q = 0;
        for (int i = 0; i < 5000 && q < 8; i++)
        begin
            @(posedge core_clk);
            #1;
            q = busy ? 0 : q + 1;
        end
        // A bus that never goes quiet is a hang, not a pass
        if (q < 8)
            failures++;
    endtask : drain

    task end_of_test;
        $display("checks_done %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // Results in order of request; a frozen pulse is taken once, on an enabled edge
    always @(posedge core_clk)
        if (ce === 1'b1 && (rd_valid === 1'b1 || rd_refused === 1'b1))
        begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 17'h1ffff;
            chk1("refused", e[16], rd_refused);
            if (!e[16])
                chk16("read word", e[15:0], rd_data);
        end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        failures++;
        end_of_test;
    end

    initial
    begin
        void'($urandom(32'h4b68d429));
        repeat (12) @(posedge core_clk);
        #1;
        chk1("reset out", 1'b0, pins.display_reset_n);
        chk1("select", 1'b1, pins.display_select_n);
        chk1("drive", 1'b0, pins.data_oe);
        rst = 1'b0;
        send(1'b1, 1'b1, 16'h0000);
        release_display = 1'b1;
        drain;
        chk1("display run", 1'b1, pins.display_reset_n);
        // Every entry written back to back, filling the queue
        full_seen = 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            send(1'b0, 1'b0, {12'($urandom), 4'(i)});
            send(1'b0, 1'b1, 16'($urandom));
        end
        chk1("queue full", 1'b1, full_seen);
        drain;
        // Back to back reads, prompt and slow display
        for (int i = 0; i < 8; i++)
        begin
            slow = i[0];
            send(1'b0, 1'b0, 16'($urandom));
            send(1'b1, 1'b1, 16'h0000);
            send(1'b1, 1'b1, 16'h0000);
        end
        // Stop offering, else the last read is queued again with no note
        cmd_valid = 1'b0;
        // Freeze in mid read
        repeat (8) @(posedge core_clk);
        #1;
        ce = 1'b0;
        repeat (20) @(posedge core_clk);
        #1;
        ce = 1'b1;
        drain;
        // Display reset forgets the index
        release_display = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        chk1("index kept", 1'b0, addr_selected);
        idx_ok = 1'b0;
        release_display = 1'b1;
        send(1'b1, 1'b1, 16'h0000);
        send(1'b0, 1'b0, 16'h0005);
        cmd_valid = 1'b0;
        // Third edge after the take: strobe low on the driven index word
        repeat (3) @(posedge core_clk);
        #1;
        chk1("busy", 1'b1, busy);
        chk1("write strobe", 1'b0, pins.write_strobe_n);
        chk1("index select", 1'b0, pins.register_select);
        chk1("chip select", 1'b0, pins.display_select_n);
        chk1("drive on write", 1'b1, pins.data_oe);
        chk16("index word", 16'h0005, pins.data_out);
        drain;
        rst = 1'b1;
        @(posedge core_clk);
        #1;
        rst = 1'b0;
        idx_ok = 1'b0;
        chk1("index after reset", 1'b0, addr_selected);
        send(1'b1, 1'b1, 16'h0000);
        drain;
        chk1("all results", 1'b1, exp_q.size() == 0);
        end_of_test;
    end
endmodule : pdb_display_bus_bench
